// ==== hw/flash_rd_pkg.sv ====
// constants and state type of the burst flash read block
`default_nettype none
package flash_rd_pkg;
    // data path and clock
    localparam int DATA_W = 16;
    localparam int CLK_MHZ = 250;
    // asynchronous access, longest time so the count rounds down
    localparam int ASYNC_ACC_NS = 70;
    localparam int ASYNC_ACC_CYC = (ASYNC_ACC_NS * CLK_MHZ) / 1000;
    // pipeline stages between pin sample and data flop, taken off the count
    localparam int ASYNC_PIPE = 3;
    localparam logic [4:0] ASYNC_LOAD = 5'(ASYNC_ACC_CYC - ASYNC_PIPE);
    // initial wait state range
    localparam logic [2:0] WAIT_MIN = 3'h2;
    localparam logic [2:0] WAIT_MAX = 3'h7;
    // boundary every 128 words, checked at burst offsets one to three
    localparam int BOUNDARY_BITS = 7;
    localparam logic [2:0] BOUNDARY_OFS_MIN = 3'h1;
    localparam logic [2:0] BOUNDARY_OFS_MAX = 3'h3;
    // wrap range of eight words
    localparam int WRAP_BITS = 3;
    // avalon register byte offsets
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MEM_ADDR = 4'h8;
    localparam logic [3:0] REG_MEM_DATA = 4'hc;
    // config fields
    localparam int CFG_W = 7;
    localparam int CFG_WAIT_LSB = 0;
    localparam int CFG_WAIT_MSB = 2;
    localparam int CFG_WRAP_BIT = 3;
    localparam int CFG_RDY_BIT = 4;
    localparam int CFG_RISE_BIT = 5;
    localparam int CFG_SYNC_BIT = 6;
    // seven wait states, no wrap, ready with data, rising edge, async mode
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h37;
    // burst sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST, ST_GAP} burst_state_t;
endpackage
`default_nettype wire

// ==== hw/word_fifo.sv ====
// synchronous word fifo with valid/ready on both sides and a flush
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("word_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    // honest full and empty from the occupancy count
    assign o_in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem[rd_q];
    assign o_level = cnt_q;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // flush drops everything, even a push in that cycle
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (i_flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) wr_d = wr_q + 1'b1;
            if (pop) rd_d = rd_q + 1'b1;
            if (push && !pop) cnt_d = cnt_q + 1'b1;
            else if (pop && !push) cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge i_clk) begin
        if (push && !i_flush) mem[wr_q] <= i_in_data;
    end
endmodule
`default_nettype wire

// ==== hw/burst_addr_gen.sv ====
// linear burst address stepper with optional eight-word wrap
`default_nettype none
module burst_addr_gen #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [ADDR_W-1:0] i_load_addr,
    input wire logic i_step,
    input wire logic i_wrap,
    output logic [ADDR_W-1:0] o_addr,
    output logic [ADDR_W-1:0] o_next,
    output logic [2:0] o_offset
);
    generate
        if (ADDR_W <= flash_rd_pkg::WRAP_BITS) begin : g_bad_width
            $error("burst_addr_gen needs more address bits than the wrap range");
        end
    endgenerate

    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [2:0] ofs_q, ofs_d;

    // wrap keeps the upper bits, plain mode carries across the range
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                   input logic wrap);
        logic [ADDR_W-1:0] r;
        r = a + 1'b1;
        if (wrap) begin
            r[ADDR_W-1:flash_rd_pkg::WRAP_BITS] = a[ADDR_W-1:flash_rd_pkg::WRAP_BITS];
        end
        return r;
    endfunction

    assign o_next = step_addr(addr_q, i_wrap);
    assign o_addr = addr_q;
    assign o_offset = ofs_q;

    // offset saturates, only the first few words of a burst matter
    always_comb begin
        addr_d = addr_q;
        ofs_d = ofs_q;
        if (i_load) begin
            addr_d = i_load_addr;
            ofs_d = '0;
        end else if (i_step) begin
            addr_d = o_next;
            if (ofs_q != 3'h7) ofs_d = ofs_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_q <= '0;
            ofs_q <= '0;
        end else begin
            addr_q <= addr_d;
            ofs_q <= ofs_d;
        end
    end
endmodule
`default_nettype wire

// ==== hw/burst_flash_read_interface.sv ====
// burst flash read interface with avalon register side
// Notes on behaviour
// - initial burst wait count is programmable from two to seven cycles total
// - crossing a boundary at burst offset one to three inserts delay, ready low
// - sync address taken at active edge with strobe low or strobe rise, first wins
// - wrap mode walks eight aligned words upward and wraps to the lowest
// - without wrap the burst address keeps counting past the eight-word range
// - ready timing bit cleared gives ready one active edge before each word
// - active flash clock edge is selectable; the selected edge samples and advances
// - async reads give data within 70 ns of later of address or strobe fall
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`default_nettype none
module burst_flash_read_interface #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = 16,
    parameter int BOUNDARY_WAIT = 2
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_FLASH_CLK,
    input wire logic I_CE_N,
    input wire logic I_OE_N,
    input wire logic I_ADDRESS_VALID_STROBE_N,
    input wire logic [ADDR_W-1:0] I_ADDR,
    output logic [flash_rd_pkg::DATA_W-1:0] O_DQ,
    output logic O_DQ_OE,
    output logic O_RDY,
    output logic O_RDY_OE,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);
    localparam int DW = flash_rd_pkg::DATA_W;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    generate
        if (BOUNDARY_WAIT < 1 || BOUNDARY_WAIT > 8 || ADDR_W > 16
            || ADDR_W < flash_rd_pkg::BOUNDARY_BITS) begin : g_bad_param
            $error("burst_flash_read_interface parameter out of range");
        end
    endgenerate

    // word array behind the pins, loaded over the register bus
    logic [DW-1:0] mem [2**ADDR_W];

    // merge written byte lanes into an old register value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // a word at this burst offset sitting on a 128-word boundary needs a gap
    function automatic logic gap_hit(input logic [ADDR_W-1:0] a, input logic [2:0] ofs);
        return (a[flash_rd_pkg::BOUNDARY_BITS-1:0] == '0)
            && (ofs >= flash_rd_pkg::BOUNDARY_OFS_MIN)
            && (ofs <= flash_rd_pkg::BOUNDARY_OFS_MAX);
    endfunction

    // register state
    logic [flash_rd_pkg::CFG_W-1:0] cfg_q, cfg_d;
    logic [ADDR_W-1:0] maddr_q, maddr_d;
    logic wreq_q, wreq_d;
    logic [31:0] rdata_q, rdata_d;
    logic mem_we;
    logic [31:0] merged;
    // pin side state
    flash_rd_pkg::burst_state_t st_q, st_d;
    logic fclk_q, avd_q, latched_q, latched_d;
    logic [2:0] cnt_q, cnt_d, gcnt_q, gcnt_d;
    logic gap_done_q, gap_done_d, fetch_q, fetch_d;
    logic [DW-1:0] dq_q, dq_d;
    logic rdy_q, rdy_d, oe_q, oe_d;
    logic [ADDR_W-1:0] lat_addr_q, lat_addr_d, aprev_q, aprev_d;
    logic [4:0] acnt_q, acnt_d;
    logic aval_q, aval_d;
    // decoded config and pin events
    logic sync_mode, wrap_en, rdy_with_data, rise_sel;
    logic [2:0] wait_eff;
    logic active_edge, avd_fall, avd_rise, capture;
    logic [ADDR_W-1:0] addr_eff;
    // fifo and address generators
    logic f_in_ready, f_out_valid, present_go;
    logic [DW-1:0] f_out_data;
    logic [LW-1:0] f_level;
    logic [ADDR_W-1:0] fetch_addr, pres_addr, pres_next;
    logic [2:0] pres_ofs;

    assign sync_mode = cfg_q[flash_rd_pkg::CFG_SYNC_BIT];
    assign wrap_en = cfg_q[flash_rd_pkg::CFG_WRAP_BIT];
    assign rdy_with_data = cfg_q[flash_rd_pkg::CFG_RDY_BIT];
    assign rise_sel = cfg_q[flash_rd_pkg::CFG_RISE_BIT];
    // field values below two act as two
    assign wait_eff = (cfg_q[flash_rd_pkg::CFG_WAIT_MSB:flash_rd_pkg::CFG_WAIT_LSB]
                       < flash_rd_pkg::WAIT_MIN) ? flash_rd_pkg::WAIT_MIN
                      : cfg_q[flash_rd_pkg::CFG_WAIT_MSB:flash_rd_pkg::CFG_WAIT_LSB];

    // edge detection on the sampled flash clock and strobe
    assign active_edge = rise_sel ? (I_FLASH_CLK && !fclk_q)
                                  : (!I_FLASH_CLK && fclk_q);
    assign avd_fall = avd_q && !I_ADDRESS_VALID_STROBE_N;
    assign avd_rise = !avd_q && I_ADDRESS_VALID_STROBE_N;
    assign capture = sync_mode && !I_CE_N && !latched_q
        && ((active_edge && !I_ADDRESS_VALID_STROBE_N) || avd_rise);
    assign addr_eff = I_ADDRESS_VALID_STROBE_N ? lat_addr_q : I_ADDR;

    word_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_flush(capture || st_q == flash_rd_pkg::ST_IDLE),
        .i_in_valid(fetch_q),
        .o_in_ready(f_in_ready),
        .i_in_data(mem[fetch_addr]),
        .o_out_valid(f_out_valid),
        .i_out_ready(present_go),
        .o_out_data(f_out_data),
        .o_level(f_level)
    );

    // fetch runs ahead and stalls when the fifo is full
    burst_addr_gen #(.ADDR_W(ADDR_W)) u_fetch_addr (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_load(capture),
        .i_load_addr(I_ADDR),
        .i_step(fetch_q && f_in_ready && !capture),
        .i_wrap(wrap_en),
        .o_addr(fetch_addr),
        .o_next(),
        .o_offset()
    );

    // tracks the next word to go on the pins, used for boundary gaps
    burst_addr_gen #(.ADDR_W(ADDR_W)) u_pres_addr (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_load(capture),
        .i_load_addr(I_ADDR),
        .i_step(present_go),
        .i_wrap(wrap_en),
        .o_addr(pres_addr),
        .o_next(pres_next),
        .o_offset(pres_ofs)
    );

    // burst sequencer; in sync mode data moves only on active flash clock edges, ready on those edges and at address capture
    always_comb begin
        logic gap_next;
        gap_next = 1'b0;
        st_d = st_q;
        cnt_d = cnt_q;
        gcnt_d = gcnt_q;
        gap_done_d = gap_done_q;
        fetch_d = fetch_q;
        present_go = 1'b0;
        dq_d = dq_q;
        rdy_d = rdy_q;
        latched_d = latched_q;
        if (I_CE_N) latched_d = 1'b0;
        else if (capture) latched_d = 1'b1;
        else if (avd_fall) latched_d = 1'b0;
        if (!sync_mode || I_CE_N) begin
            st_d = flash_rd_pkg::ST_IDLE;
            fetch_d = 1'b0;
        end else if (capture) begin
            st_d = flash_rd_pkg::ST_WAIT;
            cnt_d = wait_eff - 3'h1;
            gap_done_d = 1'b0;
            fetch_d = 1'b1;
            rdy_d = 1'b0;
        end else if (active_edge) begin
            case (st_q)
                flash_rd_pkg::ST_WAIT: begin
                    if (cnt_q == '0) present_go = f_out_valid;
                    else cnt_d = cnt_q - 3'h1;
                    if (present_go) st_d = flash_rd_pkg::ST_BURST;
                end
                flash_rd_pkg::ST_BURST: begin
                    if (!gap_done_q && gap_hit(pres_addr, pres_ofs)) begin
                        st_d = flash_rd_pkg::ST_GAP;
                        gcnt_d = 3'(BOUNDARY_WAIT - 1);
                        gap_done_d = 1'b1;
                    end else begin
                        present_go = f_out_valid;
                    end
                end
                flash_rd_pkg::ST_GAP: begin
                    if (gcnt_q == '0) present_go = f_out_valid;
                    else gcnt_d = gcnt_q - 3'h1;
                    if (present_go) st_d = flash_rd_pkg::ST_BURST;
                end
                default: st_d = flash_rd_pkg::ST_IDLE;
            endcase
            if (present_go) dq_d = f_out_data;
            // look one edge ahead for the early ready option
            gap_next = !gap_done_d && (present_go ? gap_hit(pres_next, pres_ofs + 3'h1)
                                                  : gap_hit(pres_addr, pres_ofs));
            if (rdy_with_data) begin
                rdy_d = present_go;
            end else begin
                rdy_d = (st_d == flash_rd_pkg::ST_WAIT && cnt_d == '0)
                     || (st_d == flash_rd_pkg::ST_BURST && !gap_next)
                     || (st_d == flash_rd_pkg::ST_GAP && gcnt_d == '0);
            end
        end
        // asynchronous mode drives ready high and data from the access timer
        if (!sync_mode) begin
            rdy_d = 1'b1;
            if (aval_d && !aval_q) dq_d = mem[addr_eff];
        end
    end

    // asynchronous access timer restarts on any change of the effective address (pins while strobe low, latched while high) or strobe fall
    always_comb begin
        lat_addr_d = avd_rise ? I_ADDR : lat_addr_q;
        aprev_d = addr_eff;
        acnt_d = acnt_q;
        aval_d = aval_q;
        if (addr_eff != aprev_q || avd_fall) begin
            acnt_d = flash_rd_pkg::ASYNC_LOAD;
            aval_d = 1'b0;
        end else if (acnt_q != '0) begin
            acnt_d = acnt_q - 5'h1;
        end else begin
            aval_d = 1'b1;
        end
        oe_d = !I_CE_N && !I_OE_N;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_q <= flash_rd_pkg::ST_IDLE;
            fclk_q <= 1'b0;
            avd_q <= 1'b1;
            latched_q <= 1'b0;
            cnt_q <= '0;
            gcnt_q <= '0;
            gap_done_q <= 1'b0;
            fetch_q <= 1'b0;
            dq_q <= '0;
            rdy_q <= 1'b0;
            oe_q <= 1'b0;
            lat_addr_q <= '0;
            aprev_q <= '0;
            acnt_q <= '0;
            aval_q <= 1'b0;
        end else begin
            st_q <= st_d;
            fclk_q <= I_FLASH_CLK;
            avd_q <= I_ADDRESS_VALID_STROBE_N;
            latched_q <= latched_d;
            cnt_q <= cnt_d;
            gcnt_q <= gcnt_d;
            gap_done_q <= gap_done_d;
            fetch_q <= fetch_d;
            dq_q <= dq_d;
            rdy_q <= rdy_d;
            oe_q <= oe_d;
            lat_addr_q <= lat_addr_d;
            aprev_q <= aprev_d;
            acnt_q <= acnt_d;
            aval_q <= aval_d;
        end
    end

    assign O_DQ = dq_q;
    assign O_DQ_OE = oe_q;
    assign O_RDY = rdy_q;
    assign O_RDY_OE = oe_q;

    // avalon slave: one wait cycle, answer in the cycle waitrequest is low
    always_comb begin
        logic [31:0] cur;
        cur = '0;
        cfg_d = cfg_q;
        maddr_d = maddr_q;
        rdata_d = rdata_q;
        wreq_d = !((I_AVS_READ || I_AVS_WRITE) && wreq_q);
        mem_we = 1'b0;
        case (I_AVS_ADDRESS)
            flash_rd_pkg::REG_CONFIG: cur = 32'(cfg_q);
            flash_rd_pkg::REG_STATUS: cur = {16'h0000, 8'(f_level), 3'h0, aval_q,
                                             latched_q, st_q, sync_mode};
            flash_rd_pkg::REG_MEM_ADDR: cur = 32'(maddr_q);
            flash_rd_pkg::REG_MEM_DATA: cur = 32'(mem[maddr_q]);
            default: cur = '0;
        endcase
        merged = lane_merge(cur, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        if (I_AVS_READ && wreq_q) rdata_d = cur;
        if (I_AVS_WRITE && !wreq_q) begin
            case (I_AVS_ADDRESS)
                flash_rd_pkg::REG_CONFIG: cfg_d = merged[flash_rd_pkg::CFG_W-1:0];
                flash_rd_pkg::REG_MEM_ADDR: maddr_d = merged[ADDR_W-1:0];
                flash_rd_pkg::REG_MEM_DATA: begin
                    mem_we = 1'b1;
                    maddr_d = maddr_q + 1'b1;
                end
                default: mem_we = 1'b0;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cfg_q <= flash_rd_pkg::CFG_RESET;
            maddr_q <= '0;
            wreq_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            maddr_q <= maddr_d;
            wreq_q <= wreq_d;
            rdata_q <= rdata_d;
        end
    end

    // array write port; byte enables pick the halves of the word
    always_ff @(posedge I_CLK) begin
        if (mem_we) begin
            mem[maddr_q] <= merged[DW-1:0];
        end
    end

    assign O_AVS_READDATA = rdata_q;
    assign O_AVS_WAITREQUEST = wreq_q;
endmodule
`default_nettype wire

// ==== testbench/flash_rd_props.sv ====
// assertion checker for the flash read block
`default_nettype none
module flash_rd_props (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE_N,
    input wire logic I_OE_N,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [flash_rd_pkg::DATA_W-1:0] O_DQ,
    input wire logic O_DQ_OE,
    input wire logic O_RDY_OE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // request while waiting, then one answer cycle
    sequence s_req;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    endsequence
    sequence s_answer;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    sequence s_off;
        I_CE_N [*2];
    endsequence
    property p_oe_follow;
        !$past(I_RST) |-> O_DQ_OE == (!$past(I_CE_N) && !$past(I_OE_N));
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("dq enable wrong");
    property p_rdy_oe;
        O_RDY_OE == O_DQ_OE;
    endproperty
    a_rdy_oe: assert property (p_rdy_oe) else $error("ready enable differs");
    property p_deselect;
        s_off |-> !O_DQ_OE && !O_RDY_OE;
    endproperty
    a_deselect: assert property (p_deselect) else $error("pins driven deselected");
    property p_answer;
        s_req |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("late bus answer");
    property p_idle;
        !(I_AVS_READ || I_AVS_WRITE) |=> O_AVS_WAITREQUEST;
    endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_cause;
        !O_AVS_WAITREQUEST |-> $past(O_AVS_WAITREQUEST) && $past(I_AVS_READ || I_AVS_WRITE);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    // read data moves only when a read is answered
    property p_rdata;
        $changed(O_AVS_READDATA) |-> !O_AVS_WAITREQUEST && $past(I_AVS_READ);
    endproperty
    a_rdata: assert property (p_rdata) else $error("stray read data");
    property p_reset;
        $fell(I_RST) |-> O_AVS_WAITREQUEST && !O_DQ_OE && O_DQ == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset outputs");
endmodule
bind burst_flash_read_interface flash_rd_props u_flash_rd_props (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_CE_N(I_CE_N), .I_OE_N(I_OE_N), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_RDY_OE(O_RDY_OE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));
`default_nettype wire

// ==== testbench/flash_host_model.sv ====
// host controller model for the flash pins
`default_nettype none
module flash_host_model (
    input wire logic i_clk,
    input wire logic [15:0] i_dq,
    input wire logic i_rdy,
    output logic o_flash_clk,
    output logic o_ce_n = 1'b1,
    output logic o_oe_n = 1'b1,
    output logic o_strb_n = 1'b1,
    output logic [7:0] o_addr = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic raw_q = 1'b0;
    logic fall_q = 1'b0;
    logic [15:0] got[$];
    int first_edge;
    int slips;
    // clock idles between frames; falling mode inverts the pin
    assign o_flash_clk = raw_q ^ fall_q;
    // one burst, eight system cycles per flash clock
    task automatic burst(input logic [7:0] a, input int n, input logic [6:0] cfg, input bit late);
        int e;
        bit pend;
        bit early;
        got.delete();
        first_edge = -1;
        slips = 0;
        pend = 0;
        early = !cfg[flash_rd_pkg::CFG_RDY_BIT];
        e = late;
        fall_q <= !cfg[flash_rd_pkg::CFG_RISE_BIT];
        @(posedge i_clk);
        o_ce_n <= 1'b0;
        o_oe_n <= 1'b0;
        o_strb_n <= 1'b0;
        o_addr <= a;
        repeat (3) @(posedge i_clk);
        if (late) o_strb_n <= 1'b1; // capture by strobe rise before any edge
        repeat (3) @(posedge i_clk);
        while (got.size() < n && e < 40) begin // never suspended
            raw_q <= 1'b1;
            repeat (2) @(posedge i_clk);
            // address hold over: released lines show the inverse
            o_strb_n <= 1'b1;
            o_addr <= ~a;
            repeat (2) @(posedge i_clk);
            raw_q <= 1'b0;
            repeat (4) @(posedge i_clk);
            if (pend || (!early && i_rdy === 1'b1)) begin
                got.push_back(i_dq);
                if (first_edge < 0) first_edge = e;
            end else if (first_edge >= 0) slips++;
            pend = early && i_rdy === 1'b1;
            e++;
        end
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
    endtask
    // async read, then again with the address latched
    task automatic async_rd(input logic [7:0] a, output logic [15:0] live, output logic [15:0] held);
        @(posedge i_clk);
        o_ce_n <= 1'b0;
        o_oe_n <= 1'b0;
        o_strb_n <= 1'b0;
        o_addr <= a;
        repeat (17) @(posedge i_clk);
        #1 live = i_dq;
        @(posedge i_clk);
        o_strb_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_addr <= ~a;
        repeat (17) @(posedge i_clk);
        #1 held = i_dq;
        @(posedge i_clk);
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the burst flash read block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BW = 2;
    logic clk;
    logic rst = 1'b1;
    logic fclk, ce_n, oe_n, strb_n, dq_oe, rdy, rdy_oe, av_wait;
    logic [7:0] addr;
    logic [15:0] dq;
    logic [3:0] av_addr = 4'h0;
    logic [3:0] av_be = 4'hf;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rdata;
    int num_errors = 0;
    int tests_run = 0;
    burst_flash_read_interface #(.ADDR_W(8), .FIFO_DEPTH(16), .BOUNDARY_WAIT(BW))
        u_burst_flash_read_interface (.I_CLK(clk), .I_RST(rst), .I_FLASH_CLK(fclk),
        .I_CE_N(ce_n), .I_OE_N(oe_n), .I_ADDRESS_VALID_STROBE_N(strb_n), .I_ADDR(addr),
        .O_DQ(dq), .O_DQ_OE(dq_oe), .O_RDY(rdy), .O_RDY_OE(rdy_oe), .I_AVS_ADDRESS(av_addr),
        .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd),
        .I_AVS_BYTEENABLE(av_be), .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait));
    flash_host_model u_flash_host_model (.i_clk(clk), .i_dq(dq), .i_rdy(rdy), .o_flash_clk(fclk),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_strb_n(strb_n), .o_addr(addr));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [15:0] pat(input logic [7:0] a);
        return {~a, a};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one avalon access, held until waitrequest is low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        av_addr <= a;
        av_wd <= wd;
        av_rd <= !wr;
        av_wr <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 100);
        rd = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (n >= 100) check("bus answer", 32'h1, 32'h0);
    endtask
    // one burst: latency, gap and word order
    task automatic run(input string name, input logic [6:0] cfg, input logic [7:0] a,
                       input bit late, input int n, input int gap);
        logic [31:0] rd;
        logic [7:0] x;
        av_xfer(1'b1, flash_rd_pkg::REG_CONFIG, 32'(cfg), rd);
        u_flash_host_model.burst(a, n, cfg, late);
        check({name, " first"}, 32'(u_flash_host_model.first_edge), 32'(cfg[2:0]));
        check({name, " gap"}, 32'(u_flash_host_model.slips), 32'(gap));
        for (int k = 0; k < n; k++) begin
            x = cfg[flash_rd_pkg::CFG_WRAP_BIT] ? {a[7:3], a[2:0] + 3'(k)} : a + 8'(k);
            check({name, " word"}, 32'(u_flash_host_model.got[k]), 32'(pat(x)));
        end
        repeat (3) @(posedge clk);
        check({name, " release"}, {30'h0, dq_oe, rdy_oe}, 32'h0);
        $display("test %s done", name);
    endtask
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] rd;
        logic [15:0] live, held;
        repeat (3) @(posedge clk);
        rst <= 1'b0; // short stand-in for the host's hold
        av_xfer(1'b0, flash_rd_pkg::REG_CONFIG, 32'h0, rd);
        check("config reset", rd, 32'h37);
        av_xfer(1'b0, 4'h6, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        av_be <= 4'h2;
        av_xfer(1'b1, flash_rd_pkg::REG_CONFIG, 32'h0, rd);
        av_be <= 4'hf;
        av_xfer(1'b0, flash_rd_pkg::REG_CONFIG, 32'h0, rd);
        check("config lanes", rd, 32'h37);
        av_xfer(1'b1, flash_rd_pkg::REG_MEM_ADDR, 32'h0, rd);
        for (int i = 0; i < 256; i++) av_xfer(1'b1, flash_rd_pkg::REG_MEM_DATA, 32'(pat(8'(i))), rd);
        av_xfer(1'b1, flash_rd_pkg::REG_MEM_ADDR, 32'h7e, rd);
        av_xfer(1'b0, flash_rd_pkg::REG_MEM_DATA, 32'h0, rd);
        check("array", rd, 32'(pat(8'h7e)));
        $display("test registers done");
        for (int w = 2; w <= 7; w++) run("waits", 7'h70 | 7'(w), 8'h10, 1'b0, 3, 0);
        run("wrap", 7'h7b, 8'h7c, 1'b0, 8, 0);
        run("nowrap", 7'h73, 8'h7e, 1'b0, 5, BW);
        run("early", 7'h64, 8'h20, 1'b0, 3, 0);
        run("falling", 7'h52, 8'h30, 1'b0, 3, 0);
        run("strobe", 7'h73, 8'h40, 1'b1, 3, 0);
        av_xfer(1'b1, flash_rd_pkg::REG_CONFIG, 32'h37, rd);
        for (int i = 0; i < 2; i++) begin
            u_flash_host_model.async_rd(8'h55 << i, live, held);
            check("async live", 32'(live), 32'(pat(8'h55 << i)));
            check("async held", 32'(held), 32'(pat(8'h55 << i)));
        end
        $display("test async done");
        end_of_test();
    end
endmodule
`default_nettype wire
